// File: verilog/flash_host_pkg.sv
package flash_host_pkg;

    localparam int ADDR_W = 23;
    localparam int DATA_W = 16;

    // command codes written on the data bus
    localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;
    localparam logic [7:0] CMD_WORD_PROGRAM = 8'h40;
    localparam logic [7:0] CMD_OTP_PROGRAM  = 8'hc0;
    localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
    localparam logic [7:0] CMD_CONFIRM      = 8'hd0;
    localparam logic [7:0] CMD_SUSPEND      = 8'hb0;
    localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;

    // engine_status_word bit positions
    localparam int SR_READY       = 7;
    localparam int SR_ERASE_SUSP  = 6;
    localparam int SR_PROG_ERR    = 4;
    localparam int SR_SUPPLY_ERR  = 3;
    localparam int SR_PROG_SUSP   = 2;
    localparam int SR_LOCK_ERR    = 1;

    // bus timing in ns and derived cycle counts at 100 MHz
    localparam int CLK_NS     = 10;
    localparam int T_WE_NS    = 60;
    localparam int T_ACC_NS   = 90;
    localparam int T_HOLD_NS  = 20;
    localparam int WE_CYC     = (T_WE_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACC_CYC    = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC   = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W      = 4;

    typedef enum logic [3:0] {
        OP_PROGRAM      = 4'h0,
        OP_OTP_PROGRAM  = 4'h1,
        OP_ERASE        = 4'h2,
        OP_SUSPEND      = 4'h3,
        OP_RESUME       = 4'h4,
        OP_READ_STATUS  = 4'h5,
        OP_CLEAR_STATUS = 4'h6,
        OP_READ_ARRAY   = 4'h7,
        OP_READ         = 4'h8
    } op_t;

    typedef struct packed {
        op_t               op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic              poll;
    } req_t;

    typedef struct packed {
        logic              ready;
        logic              erase_suspended;
        logic              prog_error;
        logic              supply_error;
        logic              prog_suspended;
        logic              lock_error;
    } status_t;

endpackage : flash_host_pkg

// File: verilog/flash_command_write_engine.sv
`timescale 1ns/1ps

// Overview of operation
// (RULE_01) program: setup code 40h then data, both to the same address
// (RULE_02) status bit 7 is one when engine ready, zero while busy
// (RULE_03) bit 3 supply fault, bit 4 program fail, bit 1 locked block
// (RULE_04) error bits stay set until clear-status 50h is written
// (RULE_05) host clears error bits before continuing after an error
// (RULE_06) read-array FFh returns partition to array reads after programming
// (RULE_07) full error check after each program or once after a sequence
// (RULE_08) suspend B0h halts programming; bit 2 shows suspended or completed
// (RULE_09) during program suspend other blocks may be read
// (RULE_10) resume D0h written to the suspended block continues the operation
// (RULE_11) status refreshes only on a new read cycle after suspend
// (RULE_12) erase suspend reports bit 6 suspended or already completed
// (RULE_13) during erase suspend other blocks may be read or programmed
// (RULE_14) protection programming: C0h then data; bad address gives error
// (RULE_15) only one partition programs or erases at a time
// (RULE_16) partitions keep their last read mode until a new command
// (RULE_17) engine next state ignores partition read output mode
// (RULE_18) bit 7 is zero for the whole operation, one when finished
module flash_command_write_engine
    import flash_host_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                reset,
    input  wire logic                req_valid,
    output      logic                req_ready,
    input  wire req_t                req,
    output      logic                done,
    output      logic [DATA_W-1:0]   rd_data,
    output      status_t             status,
    output      logic                error,
    output      logic [ADDR_W-1:0]   flash_addr,
    output      logic                flash_ce_n,
    output      logic                flash_oe_n,
    output      logic                flash_we_n,
    input  wire logic [DATA_W-1:0]   flash_dq_in,
    output      logic [DATA_W-1:0]   flash_dq_out,
    output      logic                flash_dq_oe_n
);

    typedef enum logic [3:0] {
        S_IDLE    = 4'h0,
        S_WR      = 4'h1,
        S_WR_GAP  = 4'h2,
        S_RD      = 4'h3,
        S_RD_GAP  = 4'h4,
        S_NEXT    = 4'h5,
        S_DONE    = 4'h6
    } state_t;

    state_t             state_q;
    req_t               req_q;
    logic [1:0]         step_q;
    logic [CNT_W-1:0]   cnt_q;
    logic [DATA_W-1:0]  wr_word;
    logic               last_step;
    logic               is_read_step;
    logic               want_poll;
    logic               busy_seen;

    ////////////////////////////////////////////////////////////////////////////
    // sequence decode: which word goes out on each step

    always_comb begin
        wr_word      = '0;
        last_step    = 1'b1;
        is_read_step = 1'b0;
        want_poll    = req_q.poll;
        case (req_q.op)
            OP_PROGRAM: begin
                wr_word   = (step_q == 2'd0) ? {8'h00, CMD_WORD_PROGRAM} : req_q.data; // RULE_01
                last_step = (step_q == 2'd1) && !req_q.poll;
                is_read_step = (step_q == 2'd2);
                last_step = last_step || is_read_step;
            end
            OP_OTP_PROGRAM: begin
                wr_word   = (step_q == 2'd0) ? {8'h00, CMD_OTP_PROGRAM} : req_q.data; // RULE_14
                last_step = ((step_q == 2'd1) && !req_q.poll) || (step_q == 2'd2);
                is_read_step = (step_q == 2'd2);
            end
            OP_ERASE: begin
                wr_word   = (step_q == 2'd0) ? {8'h00, CMD_ERASE_SETUP}
                                             : {8'h00, CMD_CONFIRM};
                last_step = ((step_q == 2'd1) && !req_q.poll) || (step_q == 2'd2);
                is_read_step = (step_q == 2'd2);
            end
            OP_SUSPEND: begin
                // suspend, then a fresh read cycle so the status word updates
                wr_word   = {8'h00, CMD_SUSPEND}; // RULE_08
                last_step = (step_q == 2'd1);
                is_read_step = (step_q == 2'd1); // RULE_11
                want_poll = 1'b1;
            end
            OP_RESUME: begin
                wr_word = {8'h00, CMD_CONFIRM}; // RULE_10
            end
            OP_READ_STATUS: begin
                wr_word   = {8'h00, CMD_READ_STATUS};
                last_step = (step_q == 2'd1);
                is_read_step = (step_q == 2'd1);
            end
            OP_CLEAR_STATUS: begin
                wr_word = {8'h00, CMD_CLEAR_STATUS}; // RULE_05
            end
            OP_READ_ARRAY: begin
                wr_word = {8'h00, CMD_READ_ARRAY}; // RULE_06
            end
            OP_READ: begin
                // partition keeps its read mode; plain read cycle only
                is_read_step = 1'b1; // RULE_09 RULE_13 RULE_16
            end
            default: begin
                wr_word = '0;
            end
        endcase
    end

    // judge the word just captured: the bus is released by the time the gap ends
    assign busy_seen = !rd_data[SR_READY];

    ////////////////////////////////////////////////////////////////////////////
    // bus sequencer

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q <= S_IDLE;
            req_q   <= '0;
            step_q  <= 2'd0;
            cnt_q   <= '0;
        end else begin
            case (state_q)
                S_IDLE: begin
                    // one operation at a time: no new request while one runs
                    if (req_valid) begin // RULE_15
                        req_q   <= req;
                        step_q  <= 2'd0;
                        cnt_q   <= '0;
                        state_q <= (req.op == OP_READ) ? S_RD : S_WR;
                    end
                end
                S_WR: begin
                    if (cnt_q == CNT_W'(WE_CYC - 1)) begin
                        cnt_q   <= '0;
                        state_q <= S_WR_GAP;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                S_WR_GAP: begin
                    if (cnt_q == CNT_W'(HOLD_CYC - 1)) begin
                        cnt_q   <= '0;
                        state_q <= S_NEXT;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                S_RD: begin
                    if (cnt_q == CNT_W'(ACC_CYC - 1)) begin
                        cnt_q   <= '0;
                        state_q <= S_RD_GAP;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                S_RD_GAP: begin
                    if (cnt_q == CNT_W'(HOLD_CYC - 1)) begin
                        cnt_q <= '0;
                        // keep polling with fresh read cycles while busy
                        if (want_poll && busy_seen && req_q.op != OP_SUSPEND &&
                            req_q.op != OP_READ_STATUS && req_q.op != OP_READ) begin
                            state_q <= S_RD; // RULE_02 RULE_18
                        end else begin
                            state_q <= S_DONE;
                        end
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                S_NEXT: begin
                    if (last_step) begin
                        state_q <= S_DONE;
                    end else begin
                        step_q  <= step_q + 2'd1;
                        state_q <= is_read_next(req_q.op, step_q) ? S_RD : S_WR;
                    end
                end
                S_DONE: begin
                    state_q <= S_IDLE;
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    function automatic logic is_read_next(input op_t op, input logic [1:0] step);
        is_read_next = (step == 2'd1) ||
                       (step == 2'd0 && (op == OP_SUSPEND || op == OP_READ_STATUS));
    endfunction : is_read_next

    ////////////////////////////////////////////////////////////////////////////
    // captured read data and decoded status

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rd_data <= '0;
        end else if (state_q == S_RD && cnt_q == CNT_W'(ACC_CYC - 1)) begin
            rd_data <= flash_dq_in;
        end
    end

    always_comb begin
        status.ready           = rd_data[SR_READY];       // RULE_02
        status.erase_suspended = rd_data[SR_ERASE_SUSP];  // RULE_12
        status.prog_error      = rd_data[SR_PROG_ERR];    // RULE_03
        status.supply_error    = rd_data[SR_SUPPLY_ERR];  // RULE_03
        status.prog_suspended  = rd_data[SR_PROG_SUSP];   // RULE_08
        status.lock_error      = rd_data[SR_LOCK_ERR];    // RULE_03
        // error bits persist in the device until cleared, so one check suffices
        error = req_q.poll && (rd_data[SR_PROG_ERR] || rd_data[SR_SUPPLY_ERR] ||
                rd_data[SR_LOCK_ERR]); // RULE_04 RULE_07
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin drive

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            flash_addr    <= '0;
            flash_dq_out  <= '0;
            flash_dq_oe_n <= 1'b1;
            flash_we_n    <= 1'b1;
            flash_oe_n    <= 1'b1;
            flash_ce_n    <= 1'b1;
        end else begin
            flash_addr    <= req_q.addr;
            flash_dq_out  <= wr_word;
            flash_dq_oe_n <= !(state_q == S_WR || state_q == S_WR_GAP);
            flash_we_n    <= !(state_q == S_WR);
            flash_oe_n    <= !(state_q == S_RD);
            flash_ce_n    <= !(state_q == S_WR || state_q == S_RD);
        end
    end

    // the engine state is the device's; the host only tracks its own bus phase
    assign req_ready = (state_q == S_IDLE); // RULE_17
    assign done      = (state_q == S_DONE);

endmodule : flash_command_write_engine

// File: verification/flash_command_write_engine_assertions.sv
`timescale 1ns/1ps
module flash_command_write_engine_checker
    import flash_host_pkg::*;
(
    input wire logic              ref_clk,
    input wire logic              reset,
    input wire logic              req_valid,
    input wire logic              req_ready,
    input wire req_t              req,
    input wire logic              done,
    input wire logic [DATA_W-1:0] rd_data,
    input wire status_t           status,
    input wire logic              flash_ce_n,
    input wire logic              flash_oe_n,
    input wire logic              flash_we_n,
    input wire logic [DATA_W-1:0] flash_dq_out,
    input wire logic              flash_dq_oe_n
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////
    AST_RST_IDLE: assert property ($fell(reset) |-> flash_we_n && flash_oe_n && flash_ce_n
        && flash_dq_oe_n && req_ready && !done) else $error("bus not idle after reset");
    AST_PROG_CODE: assert property (req_valid && req_ready && req.op == OP_PROGRAM |->
        ##[1:3] (!flash_we_n && flash_dq_out == 16'h0040)) else $error("no program setup");
    AST_CLR_CODE: assert property (req_valid && req_ready && req.op == OP_CLEAR_STATUS |->
        ##[1:3] (!flash_we_n && flash_dq_out == 16'h0050)) else $error("no clear code");
    AST_SUSP_CODE: assert property (req_valid && req_ready && req.op == OP_SUSPEND |->
        ##[1:3] (!flash_we_n && flash_dq_out == 16'h00b0)) else $error("no suspend code");
    AST_WE_WIDTH: assert property ($fell(flash_we_n) |-> !flash_we_n [*6] ##1 flash_we_n)
        else $error("write strobe width wrong");
    AST_WR_DRIVE: assert property (!flash_we_n |-> flash_oe_n && !flash_dq_oe_n && !flash_ce_n)
        else $error("write without driving bus");
    AST_RD_FLOAT: assert property (!flash_oe_n |-> flash_dq_oe_n && !flash_ce_n)
        else $error("bus driven during read");
    AST_STAT_DECODE: assert property (status.ready == rd_data[SR_READY] &&
        status.lock_error == rd_data[SR_LOCK_ERR] && status.prog_suspended == rd_data[SR_PROG_SUSP])
        else $error("status decode mismatch");
    AST_BUSY_REFUSE: assert property (req_valid && req_ready |=> !req_ready [*8])
        else $error("request taken while busy");
endmodule : flash_command_write_engine_checker

bind flash_command_write_engine flash_command_write_engine_checker chk_inst (.*);

// File: verification/flash_device_model.sv
`timescale 1ns/1ps
module flash_device_model
    import flash_host_pkg::*;
#(
    parameter logic [ADDR_W-1:0] OTP_LAST = 23'h0000ff
)(
    input  wire logic              ref_clk,
    input  wire logic [ADDR_W-1:0] flash_addr,
    input  wire logic              flash_ce_n,
    input  wire logic              flash_oe_n,
    input  wire logic              flash_we_n,
    input  wire logic [DATA_W-1:0] flash_dq_out,
    output      logic [DATA_W-1:0] flash_dq_in,
    input  wire logic [7:0]        busy_len,
    input  wire logic [1:0]        fault
);
    logic [7:0]        sr_q = 8'h80;
    logic [7:0]        busy_q = 8'h00;
    logic [1:0]        pend_q = 2'h0;
    logic              stat_q = 1'b0;
    logic              erase_q = 1'b0;
    logic              we_q = 1'b1;
    logic [DATA_W-1:0] last_q = 16'h0000;
    logic [DATA_W-1:0] mem_q [256];
    logic [DATA_W-1:0] val;
    logic [7:0]        cmd;
    logic              drv;
    assign cmd = flash_dq_out[7:0];
    assign drv = !flash_ce_n && !flash_oe_n;
    assign val = stat_q ? {8'h00, sr_q} : mem_q[flash_addr[7:0]];
    // released bus shows inverted last word so stale data never matches
    assign flash_dq_in = drv ? val : ~last_q;
    ////////////////////////////////////////
    always @(posedge ref_clk) begin
        we_q <= flash_we_n;
        if (drv) last_q <= val;
        if (busy_q != 8'h00 && !sr_q[2] && !sr_q[6]) begin
            busy_q <= busy_q - 8'h01;
            if (busy_q == 8'h01) sr_q[7] <= 1'b1;
        end
        if (!we_q && flash_we_n) begin
            pend_q <= 2'h0;
            if (pend_q == 2'h1 && fault == 2'h1) sr_q[1] <= 1'b1;
            else if (pend_q == 2'h1 && fault == 2'h2) sr_q[3] <= 1'b1;
            else if (pend_q == 2'h3 && flash_addr > OTP_LAST) sr_q[4] <= 1'b1;
            else if (pend_q != 2'h0 && (pend_q != 2'h2 || cmd == CMD_CONFIRM)) begin
                if (pend_q != 2'h2) mem_q[flash_addr[7:0]] <= flash_dq_out;
                erase_q <= pend_q == 2'h2;
                busy_q <= busy_len;
                sr_q[7] <= 1'b0;
            end else if (pend_q == 2'h0) begin
                stat_q <= cmd != CMD_READ_ARRAY;
                case (cmd)
                    CMD_WORD_PROGRAM: pend_q <= 2'h1;
                    CMD_ERASE_SETUP:  pend_q <= 2'h2;
                    CMD_OTP_PROGRAM:  pend_q <= 2'h3;
                    CMD_CLEAR_STATUS: sr_q[4:1] <= {2'b00, sr_q[2], 1'b0};
                    CMD_SUSPEND: if (!sr_q[7]) begin
                        sr_q[7] <= 1'b1;
                        sr_q[erase_q ? 6 : 2] <= 1'b1;
                    end
                    CMD_CONFIRM: if (sr_q[2] || sr_q[6]) begin
                        sr_q[7:6] <= 2'b00;
                        sr_q[2] <= 1'b0;
                    end
                    default: ;
                endcase
            end
        end
    end
endmodule : flash_device_model

// File: verification/flash_command_write_engine_tb.sv
`timescale 1ns/1ps
module flash_command_write_engine_tb
    import flash_host_pkg::*;
;
    logic              ref_clk = 1'b0;
    logic              reset = 1'b1;
    logic              req_valid = 1'b0;
    req_t              req = '0;
    logic [7:0]        busy_len = 8'h04;
    logic [1:0]        fault = 2'h0;
    logic              req_ready, done, error, flash_ce_n, flash_oe_n, flash_we_n;
    logic              flash_dq_oe_n;
    logic [DATA_W-1:0] rd_data, flash_dq_in, flash_dq_out;
    logic [ADDR_W-1:0] flash_addr;
    status_t           status;
    int                failures = 0;
    int                n_checks = 0;
    always #5 ref_clk = ~ref_clk;
    flash_command_write_engine flash_command_write_engine_inst (.*);
    flash_device_model flash_device_model_inst (.*);
    ////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cs(input logic [5:0] e);
        chk({10'h0, status}, {10'h0, e});
    endtask : cs
    task automatic run(input op_t op, input logic [ADDR_W-1:0] a, input logic [15:0] d,
                       input logic p);
        int n;
        n = 0;
        req_valid = 1'b1;
        req = '{op, a, d, p};
        @(negedge ref_clk);
        req_valid = 1'b0;
        while (done !== 1'b1 && n < 3000) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 3000) failures++;
        @(negedge ref_clk);
    endtask : run
    task automatic t_program();
        run(OP_PROGRAM, 23'h10, 16'h1234, 1'b1);
        cs(6'b100000);
        chk({15'h0, error}, 16'h0000);
        busy_len = 8'd40;
        run(OP_PROGRAM, 23'h22, 16'h5a5a, 1'b1);
        cs(6'b100000);
        busy_len = 8'h04;
        run(OP_PROGRAM, 23'h21, 16'habcd, 1'b1);
        run(OP_READ_ARRAY, 23'h10, 16'h0, 1'b0);
        run(OP_READ, 23'h10, 16'h0, 1'b0);
        chk(rd_data, 16'h1234);
    endtask : t_program
    task automatic t_faults();
        fault = 2'h1;
        run(OP_PROGRAM, 23'h30, 16'h5555, 1'b1);
        cs(6'b100001);
        chk({15'h0, error}, 16'h0001);
        fault = 2'h0;
        run(OP_READ_ARRAY, 23'h30, 16'h0, 1'b0);
        run(OP_READ_STATUS, 23'h30, 16'h0, 1'b0);
        cs(6'b100001);
        run(OP_CLEAR_STATUS, 23'h30, 16'h0, 1'b0);
        run(OP_READ_STATUS, 23'h30, 16'h0, 1'b0);
        cs(6'b100000);
        fault = 2'h2;
        run(OP_PROGRAM, 23'h31, 16'h0001, 1'b1);
        fault = 2'h0;
        run(OP_PROGRAM, 23'h32, 16'h0002, 1'b1);
        cs(6'b100100);
        run(OP_CLEAR_STATUS, 23'h0, 16'h0, 1'b0);
        run(OP_OTP_PROGRAM, 23'h80, 16'h0003, 1'b1);
        cs(6'b100000);
        run(OP_OTP_PROGRAM, 23'h7fffff, 16'h0003, 1'b1);
        cs(6'b101000);
        run(OP_CLEAR_STATUS, 23'h0, 16'h0, 1'b0);
    endtask : t_faults
    task automatic t_suspend();
        busy_len = 8'd200;
        run(OP_PROGRAM, 23'h40, 16'h0f0f, 1'b0);
        run(OP_SUSPEND, 23'h40, 16'h0, 1'b0);
        cs(6'b100010);
        run(OP_READ_ARRAY, 23'h10, 16'h0, 1'b0);
        run(OP_READ, 23'h10, 16'h0, 1'b0);
        chk(rd_data, 16'h1234);
        run(OP_RESUME, 23'h40, 16'h0, 1'b0);
        run(OP_READ_STATUS, 23'h40, 16'h0, 1'b0);
        cs(6'b000000);
        repeat (250) @(negedge ref_clk);
        run(OP_READ_STATUS, 23'h40, 16'h0, 1'b0);
        cs(6'b100000);
        busy_len = 8'd2;
        run(OP_PROGRAM, 23'h41, 16'h0001, 1'b0);
        run(OP_SUSPEND, 23'h41, 16'h0, 1'b0);
        cs(6'b100000);
        busy_len = 8'd200;
        run(OP_ERASE, 23'h50, 16'h0, 1'b0);
        run(OP_SUSPEND, 23'h50, 16'h0, 1'b0);
        cs(6'b110000);
        run(OP_READ_ARRAY, 23'h21, 16'h0, 1'b0);
        run(OP_READ, 23'h21, 16'h0, 1'b0);
        chk(rd_data, 16'habcd);
        run(OP_RESUME, 23'h50, 16'h0, 1'b0);
        repeat (250) @(negedge ref_clk);
        run(OP_READ_STATUS, 23'h50, 16'h0, 1'b0);
        cs(6'b100000);
    endtask : t_suspend
    task automatic end_of_test();
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    // generous bound: whole sequence needs well under a tenth of this
    initial begin
        #200000;
        failures++;
        end_of_test();
    end
    initial begin
        repeat (3) @(negedge ref_clk);
        reset = 1'b0;
        t_program();
        t_faults();
        t_suspend();
        end_of_test();
    end
endmodule : flash_command_write_engine_tb
